/* core/tcts_top.sv */
// timer clock source and timebase selection with axi4-lite register access
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - each period timer has a 4-bit clock source field in bits 3..0; codes 9 to 15 are reserved.
// - code 0 clocks a timer from its own routed external pin, separate for timers two, four, six.
// - codes 1 to 6 pick sysclk/4, sysclk, fast, slow, 31 kHz medium and secondary oscillators.
// - code 7 picks the reference clock output and code 8 the zero-cross output for every timer.
// - bits 7..4 of each timer clock register are unimplemented and read as zero.
// - the clock source field resets to zero on every reset, selecting the routed pin.
// - bits 7..6: pwm four timebase, 11 timer six, 10 timer four, 01 timer two, 00 reserved.
// - bits 5..4 give the pwm three timebase with the same encoding, 00 reserved.
// - bits 3..2 give capcomp two timer five, three or one for 11, 10, 01 in capture/compare mode.
// - bits 1..0 give capcomp one the same encoding in capture/compare mode, 00 reserved.
// - the timebase register resets to 0x55, every field at 01.
module tcts_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // clock sources, asynchronous to aclk
  input  wire logic        timer_two_pin_route,
  input  wire logic        timer_four_pin_route,
  input  wire logic        timer_six_pin_route,
  input  wire logic        high_freq_internal_osc,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        medium_freq_internal_osc,
  input  wire logic        secondary_osc,
  input  wire logic        reference_clock_output,
  input  wire logic        zero_cross_output,
  // timer periods, same clock domain, for the unit timebases
  input  wire logic        timer_one_period,
  input  wire logic        timer_two_period,
  input  wire logic        timer_three_period,
  input  wire logic        timer_four_period,
  input  wire logic        timer_five_period,
  input  wire logic        timer_six_period,
  // capcomp units in pwm mode
  input  wire logic        capcomp_one_pwm_mode,
  input  wire logic        capcomp_two_pwm_mode,
  // selected timer clocks, as aclk-sampled levels
  output logic             timer_two_clk,
  output logic             timer_four_clk,
  output logic             timer_six_clk,
  // selected unit timebases
  output logic             capcomp_unit_one_tick,
  output logic             capcomp_unit_two_tick,
  output logic             pwm_unit_three_tick,
  output logic             pwm_unit_four_tick
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] clk_sel_two;
  logic [3:0] clk_sel_four;
  logic [3:0] clk_sel_six;
  logic [7:0] timebase;
  logic [1:0] div_cnt;
  logic       sys_div4;
  logic       sys_toggle;

  // synchronisers: stage one feeds stage two only
  logic [8:0] src_meta;
  logic [8:0] src_sync;

  // write path state
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [7:0] w_data;
  logic       w_lane0;
  logic       wr_commit;

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // clock source mux for one timer; reserved codes give a still low clock
  function automatic logic pick_clock(input logic [3:0] code, input logic pin,
                                      input logic [8:0] s, input logic div4,
                                      input logic sysclk);
    case (code)
      tcts_pkg::CS_PIN:      pick_clock = pin;
      tcts_pkg::CS_SYS_DIV4: pick_clock = div4;
      tcts_pkg::CS_SYS:      pick_clock = sysclk;
      tcts_pkg::CS_HFOSC:    pick_clock = s[3];
      tcts_pkg::CS_LFOSC:    pick_clock = s[4];
      tcts_pkg::CS_MFOSC:    pick_clock = s[5];
      tcts_pkg::CS_SECOSC:   pick_clock = s[6];
      tcts_pkg::CS_REFCLK:   pick_clock = s[7];
      tcts_pkg::CS_ZCD:      pick_clock = s[8];
      default:               pick_clock = 1'b0;
    endcase
  endfunction : pick_clock

  // timebase mux for a 2-bit choice field; 00 gives no timebase
  function automatic logic pick_base(input logic [1:0] code, input logic lo,
                                     input logic mid, input logic hi);
    case (code)
      tcts_pkg::SEL_LOW:  pick_base = lo;
      tcts_pkg::SEL_MID:  pick_base = mid;
      tcts_pkg::SEL_HIGH: pick_base = hi;
      default:            pick_base = 1'b0;
    endcase
  endfunction : pick_base

  ////////////////////////////////////////////////////////////////////////////////
  // source synchronisers and system clock derivatives
  // the fastest usable source is half of aclk; faster oscillators alias
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_meta <= 9'h000;
      src_sync <= 9'h000;
    end
    else
    begin
      src_meta <= {zero_cross_output, reference_clock_output, secondary_osc,
                   medium_freq_internal_osc, low_freq_internal_osc,
                   high_freq_internal_osc, timer_six_pin_route,
                   timer_four_pin_route, timer_two_pin_route};
      src_sync <= src_meta;
    end
  end

  // sysclk seen as a level toggles each cycle; div4 is high one cycle in four
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt    <= 2'h0;
      sys_div4   <= 1'b0;
      sys_toggle <= 1'b0;
    end
    else
    begin
      div_cnt    <= div_cnt + 2'h1;
      sys_div4   <= (div_cnt == tcts_pkg::DIV4_LAST);
      sys_toggle <= ~sys_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // selected timer clocks
  // a reserved code parks the output low so the timer never sees a false edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_two_clk  <= 1'b0;
      timer_four_clk <= 1'b0;
      timer_six_clk  <= 1'b0;
    end
    else
    begin
      timer_two_clk  <= pick_clock(clk_sel_two, src_sync[0], src_sync, sys_div4, sys_toggle);
      timer_four_clk <= pick_clock(clk_sel_four, src_sync[1], src_sync, sys_div4, sys_toggle);
      timer_six_clk  <= pick_clock(clk_sel_six, src_sync[2], src_sync, sys_div4, sys_toggle);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // selected unit timebases
  // ticks follow the chosen period one edge late; the mode input is sampled on that same edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capcomp_unit_one_tick <= 1'b0;
      capcomp_unit_two_tick <= 1'b0;
      pwm_unit_three_tick   <= 1'b0;
      pwm_unit_four_tick    <= 1'b0;
    end
    else
    begin
      capcomp_unit_one_tick <= capcomp_one_pwm_mode
        ? pick_base(timebase[tcts_pkg::C1_LSB +: 2], timer_two_period,
                    timer_four_period, timer_six_period)
        : pick_base(timebase[tcts_pkg::C1_LSB +: 2], timer_one_period,
                    timer_three_period, timer_five_period);
      capcomp_unit_two_tick <= capcomp_two_pwm_mode
        ? pick_base(timebase[tcts_pkg::C2_LSB +: 2], timer_two_period,
                    timer_four_period, timer_six_period)
        : pick_base(timebase[tcts_pkg::C2_LSB +: 2], timer_one_period,
                    timer_three_period, timer_five_period);
      pwm_unit_three_tick <= pick_base(timebase[tcts_pkg::P3_LSB +: 2], timer_two_period,
                                       timer_four_period, timer_six_period);
      pwm_unit_four_tick  <= pick_base(timebase[tcts_pkg::P4_LSB +: 2], timer_two_period,
                                       timer_four_period, timer_six_period);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi write: address and data taken in either order, response after both
  assign wr_commit = aw_held && w_held && !s_axi_bvalid;

  // write address channel; awready stays low until the response is accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      aw_addr       <= 4'h0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
  end

  // write data channel; only byte lane 0 carries register bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held       <= 1'b0;
      w_data       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata[7:0];
      w_lane0      <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
  end

  // write response; a misaligned address answers slverr and changes nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tcts_pkg::RESP_OKAY;
    end
    else if (wr_commit)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[1:0] == 2'h0) ? tcts_pkg::RESP_OKAY : tcts_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register update on the cycle the response is raised
  // a cleared lane-0 strobe still answers okay but leaves every register alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_sel_two  <= tcts_pkg::CS_RESET;
      clk_sel_four <= tcts_pkg::CS_RESET;
      clk_sel_six  <= tcts_pkg::CS_RESET;
      timebase     <= tcts_pkg::TIMEBASE_RESET;
    end
    else if (wr_commit && w_lane0)
    begin
      case (aw_addr)
        tcts_pkg::ADDR_CLK_TWO:  clk_sel_two  <= w_data[tcts_pkg::CS_MSB:tcts_pkg::CS_LSB];
        tcts_pkg::ADDR_CLK_FOUR: clk_sel_four <= w_data[tcts_pkg::CS_MSB:tcts_pkg::CS_LSB];
        tcts_pkg::ADDR_CLK_SIX:  clk_sel_six  <= w_data[tcts_pkg::CS_MSB:tcts_pkg::CS_LSB];
        tcts_pkg::ADDR_TIMEBASE: timebase     <= w_data;
        default:                 timebase     <= timebase;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi read: one read at a time, answer one cycle after the address
  // misaligned and unmapped reads answer slverr with zero data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tcts_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= tcts_pkg::RESP_OKAY;
      case (s_axi_araddr)
        tcts_pkg::ADDR_CLK_TWO:  s_axi_rdata <= {28'h0000000, clk_sel_two};
        tcts_pkg::ADDR_CLK_FOUR: s_axi_rdata <= {28'h0000000, clk_sel_four};
        tcts_pkg::ADDR_CLK_SIX:  s_axi_rdata <= {28'h0000000, clk_sel_six};
        tcts_pkg::ADDR_TIMEBASE: s_axi_rdata <= {24'h000000, timebase};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= tcts_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : tcts_top

/* dv/tcts_top_bench.sv */
// self-checking bench for the timer clock select block
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tcts_top_bench;
  localparam logic [1:0] OK = tcts_pkg::RESP_OKAY;
  localparam logic [1:0] ER = tcts_pkg::RESP_SLVERR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  src = 9'h000;
  logic [5:0]  per = 6'h00;
  logic        capcomp_one_pwm_mode = 1'b0, capcomp_two_pwm_mode = 1'b0;
  logic        timer_two_clk, timer_four_clk, timer_six_clk;
  logic        capcomp_unit_one_tick, capcomp_unit_two_tick;
  logic        pwm_unit_three_tick, pwm_unit_four_tick;
  int          n_mismatch = 0, compares = 0;
  // source bits: 0..2 routed pins of timers two/four/six, 3..8 at their own codes
  wire timer_two_pin_route = src[0], timer_four_pin_route = src[1];
  wire timer_six_pin_route = src[2], high_freq_internal_osc = src[3];
  wire low_freq_internal_osc = src[4], medium_freq_internal_osc = src[5];
  wire secondary_osc = src[6], reference_clock_output = src[7], zero_cross_output = src[8];
  wire timer_one_period = per[0], timer_two_period = per[1], timer_three_period = per[2];
  wire timer_four_period = per[3], timer_five_period = per[4], timer_six_period = per[5];
  wire [2:0] tclk = {timer_six_clk, timer_four_clk, timer_two_clk};
  wire [3:0] tick = {pwm_unit_four_tick, pwm_unit_three_tick, capcomp_unit_two_tick,
                     capcomp_unit_one_tick};

  tcts_top u_tcts_top (.*);

  always #50 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // master raises bready with the request, so the answer is taken at its first edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, s_axi_bvalid, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    chk("rresp", {29'h0, 1'b1, er}, {29'h0, s_axi_rvalid, s_axi_rresp});
    chk("rdata", ed, s_axi_rdata);
  endtask : rd

  function automatic logic [3:0] exp_tick(input logic [7:0] v, input logic md, input int k);
    logic [3:0] r;
    int         s;
    logic       ev;
    for (int u = 0; u < 4; u++)
    begin
      s = int'(v[2*u +: 2]);
      ev = (u >= 2) || (u == 0 ? md : !md);
      r[u] = (s != 0) && (k == (ev ? 2*s - 1 : 2*s - 2));
    end
    return r;
  endfunction : exp_tick

  task automatic give_verdict();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [3:0] ca [3];
    logic [8:0] m;
    logic [7:0] v;
    int         e;
    logic [31:0] c;
    ca = '{tcts_pkg::ADDR_CLK_TWO, tcts_pkg::ADDR_CLK_FOUR, tcts_pkg::ADDR_CLK_SIX};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int t = 0; t < 3; t++)
      rd(ca[t], 32'h0, OK);
    rd(tcts_pkg::ADDR_TIMEBASE, 32'h55, OK);
    wr(ca[0], 8'hFF, 4'hF, OK);
    rd(ca[0], 32'hF, OK);
    wr(ca[0], 8'h03, 4'h0, OK);
    rd(ca[0], 32'hF, OK);
    wr(4'h1, 8'h01, 4'hF, ER);
    rd(4'hD, 32'h0, ER);
    // selected source high, then all others high and it low
    for (int t = 0; t < 3; t++)
      for (int cd = 0; cd < 16; cd++)
      begin
        wr(ca[t], 8'(cd), 4'hF, OK);
        m = (cd == 0) ? 9'(1 << t) : 9'(1 << cd);
        for (int p = 0; p < 2; p++)
        begin
          @(posedge aclk);
          src <= p ? ~m : m;
          repeat (4) @(negedge aclk);
          c = 32'h0;
          repeat (8) @(negedge aclk) c += 32'(tclk[t]);
          e = (cd == 1) ? 2 : (cd == 2) ? 4 : (cd > 8 || p == 1) ? 0 : 8;
          chk("clk highs", e, c);
        end
      end
    // fields rotated so a swapped field position shows
    for (int f = 0; f < 4; f++)
    begin
      for (int i = 0; i < 4; i++)
        v[2*i +: 2] = 2'(f + i);
      wr(tcts_pkg::ADDR_TIMEBASE, v, 4'hF, OK);
      rd(tcts_pkg::ADDR_TIMEBASE, {24'h0, v}, OK);
      for (int md = 0; md < 2; md++)
        for (int k = 0; k < 6; k++)
        begin
          @(posedge aclk);
          capcomp_one_pwm_mode <= md[0];
          capcomp_two_pwm_mode <= !md[0];
          per <= 6'(1 << k);
          @(posedge aclk);
          per <= 6'h00;
          @(negedge aclk);
          chk("ticks", exp_tick(v, md[0], k), tick);
        end
    end
    // second reset in mid-run: every select must return to its reset value
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int t = 0; t < 3; t++)
      rd(ca[t], 32'h0, OK);
    rd(tcts_pkg::ADDR_TIMEBASE, 32'h55, OK);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end
endmodule : tcts_top_bench

/* dv/tcts_top_sva.sv */
// concurrent checks on the timer clock select block ports
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tcts_top_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // timer periods and unit modes
  input wire logic        timer_one_period,
  input wire logic        timer_two_period,
  input wire logic        timer_three_period,
  input wire logic        timer_four_period,
  input wire logic        timer_five_period,
  input wire logic        timer_six_period,
  input wire logic        capcomp_one_pwm_mode,
  input wire logic        capcomp_two_pwm_mode,
  // unit ticks
  input wire logic        capcomp_unit_one_tick,
  input wire logic        capcomp_unit_two_tick,
  input wire logic        pwm_unit_three_tick,
  input wire logic        pwm_unit_four_tick
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_pwm_unit_four_source:
  assert property (pwm_unit_four_tick |-> $past(timer_two_period | timer_four_period
    | timer_six_period)) else $error("pwm four tick without an even timer period");
  chk_pwm_unit_three_source:
  assert property (pwm_unit_three_tick |-> $past(timer_two_period | timer_four_period
    | timer_six_period)) else $error("pwm three tick without an even timer period");
  chk_cc2_capture:
  assert property (capcomp_unit_two_tick && !$past(capcomp_two_pwm_mode) |-> $past(
    timer_one_period | timer_three_period | timer_five_period))
    else $error("capcomp two tick without an odd timer period");
  chk_cc1_capture:
  assert property (capcomp_unit_one_tick && !$past(capcomp_one_pwm_mode) |-> $past(
    timer_one_period | timer_three_period | timer_five_period))
    else $error("capcomp one tick without an odd timer period");
  chk_cc1_pwm:
  assert property (capcomp_unit_one_tick && $past(capcomp_one_pwm_mode) |-> $past(
    timer_two_period | timer_four_period | timer_six_period))
    else $error("capcomp one pwm tick without an even timer period");
  chk_cc2_pwm:
  assert property (capcomp_unit_two_tick && $past(capcomp_two_pwm_mode) |-> $past(
    timer_two_period | timer_four_period | timer_six_period))
    else $error("capcomp two pwm tick without an even timer period");
  chk_clk_upper:
  assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != tcts_pkg::ADDR_TIMEBASE
    |=> s_axi_rdata[31:4] == 28'h0000000) else $error("clock select upper bits not zero");
  chk_write_resp:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_read_resp:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
endmodule : tcts_top_sva

bind tcts_top tcts_top_sva u_tcts_top_sva (.*);

/* shared/tcts_pkg.sv */
// package: register map, reset values and selection codes for the timer clock select block
package tcts_pkg;

  // register byte addresses on the axi4-lite bus
  localparam logic [3:0] ADDR_CLK_TWO   = 4'h0;
  localparam logic [3:0] ADDR_CLK_FOUR  = 4'h4;
  localparam logic [3:0] ADDR_CLK_SIX   = 4'h8;
  localparam logic [3:0] ADDR_TIMEBASE  = 4'hC;

  // field positions
  localparam int CS_LSB      = 0;
  localparam int CS_MSB      = 3;
  localparam int C1_LSB      = 0;
  localparam int C2_LSB      = 2;
  localparam int P3_LSB      = 4;
  localparam int P4_LSB      = 6;

  // reset values
  localparam logic [3:0] CS_RESET       = 4'h0;
  localparam logic [7:0] TIMEBASE_RESET = 8'h55;

  // clock source codes
  localparam logic [3:0] CS_PIN      = 4'h0;
  localparam logic [3:0] CS_SYS_DIV4 = 4'h1;
  localparam logic [3:0] CS_SYS      = 4'h2;
  localparam logic [3:0] CS_HFOSC    = 4'h3;
  localparam logic [3:0] CS_LFOSC    = 4'h4;
  localparam logic [3:0] CS_MFOSC    = 4'h5;
  localparam logic [3:0] CS_SECOSC   = 4'h6;
  localparam logic [3:0] CS_REFCLK   = 4'h7;
  localparam logic [3:0] CS_ZCD      = 4'h8;

  // timer choice codes
  localparam logic [1:0] SEL_RESERVED = 2'h0;
  localparam logic [1:0] SEL_LOW      = 2'h1;
  localparam logic [1:0] SEL_MID      = 2'h2;
  localparam logic [1:0] SEL_HIGH     = 2'h3;

  // system clock divider for the divide-by-four source
  localparam logic [1:0] DIV4_LAST    = 2'h3;

  // axi responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage : tcts_pkg
